/* verilog/sgc_defs.svh */
// Summary of operation
// - Back pressure bit set applies half-duplex back pressure on the port four MAC interface.
// - Duplex bit set gives half duplex on port four, clear gives full duplex.
// - Flow control bit set enables full-duplex flow control on port four.
// - Speed bit set selects 10 Mbps on port four, clear selects 100 Mbps.
// - Duplex, flow control and speed reset values come from their strap pins.
// - Null VLAN replacement bit set substitutes the port VLAN identifier for a null one.
// - Storm threshold is 11 bits: three high bits in one register, eight in the next.
// - Storm interval is 50 ms at 100 Mbps and 500 ms at 10 Mbps.
// - Storm threshold resets to high bits 000 and low byte 0x4A.
// - Port three reduced interface edge bit set samples on the falling edge; reset 0.
// - Port four reduced interface edge bit set samples on the falling edge; reset 0.
// - LED mode bit resets from its strap; mode 0 or mode 1 indicator meanings.
// - Management read sampling edge bit, reset 0, 1 selects the fast-SPI edge.
`ifndef SGC_DEFS_SVH
`define SGC_DEFS_SVH
`define SGC_ADDR_P4 8'h06
`define SGC_ADDR_STORM_LO 8'h07
`define SGC_ADDR_FT_A 8'h08
`define SGC_ADDR_FT_B 8'h09
`define SGC_ADDR_FT_C 8'h0A
`define SGC_ADDR_EDGE 8'h0B
`define SGC_RST_STORM_HI 3'h0
`define SGC_RST_STORM_LO 8'h4A
`define SGC_RST_FT_A 8'h00
`define SGC_RST_FT_B 8'h4C
`define SGC_RST_FT_C 8'h00
`define SGC_BIT_BP 7
`define SGC_BIT_HALF 6
`define SGC_BIT_FC 5
`define SGC_BIT_SPD 4
`define SGC_BIT_NULLVID 3
`define SGC_BIT_E3 7
`define SGC_BIT_E4 6
`define SGC_BIT_PSAVE 3
`define SGC_BIT_LED 1
`define SGC_BIT_RDEDGE 0
`define SGC_STORM_HI_MSB 2
`define SGC_EDGE_WMASK 8'hCB
`define SGC_CYC_PER_MS (`SGC_CLK_HZ / 1000)
`define SGC_CLK_HZ 25000000
`define SGC_INT_FAST_MS 50
`define SGC_INT_SLOW_MS 500
`endif

/* verilog/sgc_pkg.sv */
package sgc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } sgc_req_t;
  typedef struct packed {
    logic back_pressure;
    logic half_duplex;
    logic flow_control;
    logic speed_10;
    logic null_vid_replace;
    logic [10:0] storm_threshold;
    logic port3_neg_edge;
    logic port4_neg_edge;
    logic phy_power_save;
    logic led_mode;
    logic read_alt_edge;
  } sgc_cfg_t;
endpackage

/* verilog/sgc_interval.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sgc_defs.svh"
module sgc_interval #(
  parameter int FAST_CYCLES = `SGC_CYC_PER_MS * `SGC_INT_FAST_MS,
  parameter int SLOW_CYCLES = `SGC_CYC_PER_MS * `SGC_INT_SLOW_MS
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic speed_10,
  output logic tick
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  wire [31:0] limit = speed_10 ? SLOW_CYCLES - 1 : FAST_CYCLES - 1;
  wire wrap = cnt_ff >= limit;
  assign nxt_cnt = wrap ? 32'h0 : cnt_ff + 32'h1;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_ff <= 32'h0;
      tick <= 1'h0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick <= wrap;
    end
  end
endmodule
`default_nettype wire

/* verilog/sgc_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sgc_defs.svh"
module sgc_regs #(
  parameter int FAST_CYCLES = `SGC_CYC_PER_MS * `SGC_INT_FAST_MS,
  parameter int SLOW_CYCLES = `SGC_CYC_PER_MS * `SGC_INT_SLOW_MS
) (
  input wire logic clock,
  input wire logic rstn,
  input wire sgc_pkg::sgc_req_t req,
  input wire logic duplex_strap_pin,
  input wire logic flow_control_strap_pin,
  input wire logic speed_strap_pin,
  input wire logic led_mode_strap_pin,
  output logic [7:0] rdata,
  output sgc_pkg::sgc_cfg_t cfg,
  output logic storm_interval_tick
);
  import sgc_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] p4_ff;
  logic [7:0] lo_ff;
  logic [7:0] edge_ff;
  logic strap_done_ff;

  wire wr_p4 = req.wr && (req.addr == `SGC_ADDR_P4);
  wire wr_lo = req.wr && (req.addr == `SGC_ADDR_STORM_LO);
  wire wr_edge = req.wr && (req.addr == `SGC_ADDR_EDGE);

  // Writable bits of the edge register; reserved bits 5,4,2 stay zero
  wire [7:0] edge_mask = `SGC_EDGE_WMASK;

  // ----------------------------------------
  // Register update
  // ----------------------------------------
  // Straps are caught on the first edge after release, while the pins
  // still hold their strap levels; a write in that cycle is dropped.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      p4_ff <= {5'h00, `SGC_RST_STORM_HI};
      lo_ff <= `SGC_RST_STORM_LO;
      edge_ff <= 8'h00;
      strap_done_ff <= 1'h0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'h1;
      p4_ff[`SGC_BIT_HALF] <= duplex_strap_pin;
      p4_ff[`SGC_BIT_FC] <= flow_control_strap_pin;
      p4_ff[`SGC_BIT_SPD] <= speed_strap_pin;
      edge_ff[`SGC_BIT_LED] <= led_mode_strap_pin;
    end else begin
      if (wr_p4) p4_ff <= req.wdata;
      if (wr_lo) lo_ff <= req.wdata;
      if (wr_edge) edge_ff <= req.wdata & edge_mask;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // factory defaults on read
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      unique case (req.addr)
        `SGC_ADDR_P4: rdata <= p4_ff;
        `SGC_ADDR_STORM_LO: rdata <= lo_ff;
        `SGC_ADDR_FT_A: rdata <= `SGC_RST_FT_A;
        `SGC_ADDR_FT_B: rdata <= `SGC_RST_FT_B;
        `SGC_ADDR_FT_C: rdata <= `SGC_RST_FT_C;
        `SGC_ADDR_EDGE: rdata <= edge_ff;
        default: rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Configuration outputs
  // ----------------------------------------
  // back pressure
  assign cfg.back_pressure = p4_ff[`SGC_BIT_BP];
  assign cfg.half_duplex = p4_ff[`SGC_BIT_HALF];
  assign cfg.flow_control = p4_ff[`SGC_BIT_FC];
  assign cfg.speed_10 = p4_ff[`SGC_BIT_SPD];
  assign cfg.null_vid_replace = p4_ff[`SGC_BIT_NULLVID];
  assign cfg.storm_threshold = {p4_ff[`SGC_STORM_HI_MSB:0], lo_ff};
  assign cfg.port3_neg_edge = edge_ff[`SGC_BIT_E3];
  assign cfg.port4_neg_edge = edge_ff[`SGC_BIT_E4];
  assign cfg.phy_power_save = edge_ff[`SGC_BIT_PSAVE];
  assign cfg.led_mode = edge_ff[`SGC_BIT_LED];
  assign cfg.read_alt_edge = edge_ff[`SGC_BIT_RDEDGE];

  sgc_interval #(
    .FAST_CYCLES(FAST_CYCLES),
    .SLOW_CYCLES(SLOW_CYCLES)
  ) u_interval (
    .clock(clock),
    .rstn(rstn),
    .speed_10(p4_ff[`SGC_BIT_SPD]),
    .tick(storm_interval_tick)
  );
endmodule
`default_nettype wire

/* sim/sgc_regs_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module sgc_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire sgc_pkg::sgc_req_t req,
  input wire logic duplex_strap_pin,
  input wire logic flow_control_strap_pin,
  input wire logic speed_strap_pin,
  input wire logic led_mode_strap_pin,
  input wire logic [7:0] rdata,
  input wire sgc_pkg::sgc_cfg_t cfg,
  input wire logic storm_interval_tick
);
  import sgc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // A write on the first edge after release is ignored
  sequence s_wr(a); req.wr && $past(rstn) && req.addr == a; endsequence
  property p_lo; s_wr(8'h07) |=> cfg.storm_threshold[7:0] == $past(req.wdata); endproperty
  a_lo: assert property (p_lo) else $error("low byte");
  property p_p4; s_wr(8'h06) |=> {cfg.back_pressure, cfg.half_duplex, cfg.flow_control,
    cfg.speed_10, cfg.null_vid_replace, cfg.storm_threshold[10:8]} == $past(req.wdata);
  endproperty
  a_p4: assert property (p_p4) else $error("port4");
  property p_ed; s_wr(8'h0B) |=> {cfg.port3_neg_edge, cfg.port4_neg_edge, 2'h0,
    cfg.phy_power_save, 1'h0, cfg.led_mode, cfg.read_alt_edge} == ($past(req.wdata) & 8'hCB);
  endproperty
  a_ed: assert property (p_ed) else $error("edge reg");
  property p_rlo; req.addr == 8'h07 |=> rdata == $past(cfg.storm_threshold[7:0]); endproperty
  a_rlo: assert property (p_rlo) else $error("read low");
  property p_rb; req.addr == 8'h0B |=> !rdata[5] && !rdata[4] && !rdata[2] ##0
    rdata[3] == $past(cfg.phy_power_save); endproperty
  a_rb: assert property (p_rb) else $error("read edge");
  property p_st; !$past(rstn) |=> {cfg.half_duplex, cfg.flow_control, cfg.speed_10, cfg.led_mode}
    == {duplex_strap_pin, flow_control_strap_pin, speed_strap_pin, led_mode_strap_pin};
  endproperty
  a_st: assert property (p_st) else $error("strap");
  property p_rst; disable iff (1'b0) !rstn |=> cfg.storm_threshold == 11'h04A && rdata == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_tk; storm_interval_tick |=> !storm_interval_tick [*8]; endproperty
  a_tk: assert property (p_tk) else $error("tick");
  c_wr: cover property (s_wr(8'h06));
  c_tk: cover property (storm_interval_tick);
  c_rl: cover property (!$past(rstn));
endmodule
bind sgc_regs sgc_chk chk (
  .clock(clock),
  .rstn(rstn),
  .req(req),
  .duplex_strap_pin(duplex_strap_pin),
  .flow_control_strap_pin(flow_control_strap_pin),
  .speed_strap_pin(speed_strap_pin),
  .led_mode_strap_pin(led_mode_strap_pin),
  .rdata(rdata),
  .cfg(cfg),
  .storm_interval_tick(storm_interval_tick)
);
`default_nettype wire

/* sim/sgc_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module sgc_regs_tb;
  import sgc_pkg::*;
  logic clock = 0;
  logic rstn = 0;
  logic [3:0] strap = 4'hB;
  sgc_req_t req = '0;
  logic [7:0] rdata;
  sgc_cfg_t cfg;
  logic tick;
  int mismatches = 0;
  int total_checks = 0;
  // Short intervals keep the run brief
  sgc_regs #(.FAST_CYCLES(10), .SLOW_CYCLES(100)) uut (.clock(clock), .rstn(rstn), .req(req),
    .duplex_strap_pin(strap[3]), .flow_control_strap_pin(strap[2]), .speed_strap_pin(strap[1]),
    .led_mode_strap_pin(strap[0]), .rdata(rdata), .cfg(cfg), .storm_interval_tick(tick));
  initial begin
    forever #20 clock = ~clock;
  end
  task automatic chk(string n, logic [10:0] e, logic [10:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // Control flags in struct order, one zero bit on top
  function automatic logic [10:0] cfg_flags();
    return {1'h0, cfg.back_pressure, cfg.half_duplex, cfg.flow_control, cfg.speed_10,
      cfg.null_vid_replace, cfg.port3_neg_edge, cfg.port4_neg_edge, cfg.phy_power_save,
      cfg.led_mode, cfg.read_alt_edge};
  endfunction
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clock) req = '{a, d, 1'b1};
    @(negedge clock) req.wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge clock) req.addr = a;
    @(negedge clock) chk("rdata", {3'h0, e}, {3'h0, rdata});
  endtask
  task automatic t_reset(logic [3:0] s, logic [7:0] e6, logic [7:0] eb);
    strap = s;
    rstn = 0;
    repeat (10) @(negedge clock);
    rstn = 1;
    rd(8'h06, e6);
    rd(8'h07, 8'h4A);
    rd(8'h08, 8'h00);
    rd(8'h0B, eb);
    rd(8'h20, 8'h00);
    chk("cfg_rst", {2'h0, s[3:1], 4'h0, s[0], 1'h0}, cfg_flags());
  endtask
  task automatic t_write();
    wr(8'h06, 8'hFF);
    wr(8'h07, 8'h55);
    wr(8'h0B, 8'hFF);
    wr(8'h09, 8'h00);
    chk("thr", 11'h755, cfg.storm_threshold);
    chk("cfg_set", 11'h3FF, cfg_flags());
    rd(8'h06, 8'hFF);
    rd(8'h09, 8'h4C);
    rd(8'h0B, 8'hCB);
  endtask
  task automatic t_tick(logic [7:0] v, int lo, int hi);
    int n = 0;
    wr(8'h06, v);
    chk("cfg_p4", {1'h0, v[7:3], 5'h1F}, cfg_flags());
    repeat (200) begin
      @(negedge clock);
      n += int'(tick);
    end
    chk("ticks", 11'h1, {10'h0, n >= lo && n <= hi});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    t_reset(4'hB, 8'h50, 8'h02);
    t_write();
    t_tick(8'h00, 19, 21);
    t_tick(8'h10, 1, 3);
    t_reset(4'h4, 8'h20, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
